// ### rtl/cpu_status_flags.sv
// module: condition and system-state flag register with an Avalon-MM slave
//
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps

// How it works
// [RQ1] expired flag cleared by reset, clear, halt
// [RQ2] power-down flag cleared by reset, clear
// [RQ3] halt sets the power-down flag
// [RQ4] signed-range is carry-in xor carry-out of msb
// [RQ5] null-result set when result is zero
// [RQ6] nibble-carry follows low-nibble carry/no-borrow
// [RQ7] sign-compare is signed-range xor result msb
// [RQ8] outflow follows carry, no-borrow, rotate
// [RQ9] watchdog timeout sets expired flag
// [RQ10] software writes keep expired, power-down flags
// [RQ11] bits 7-4 read-only, bits 3-0 writable
module cpu_status_flags (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [cpu_status_flags_pkg::AddrWidth-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire cpu_status_flags_pkg::alu_flags_s aluFlags,
  input wire cpu_status_flags_pkg::sys_events_s sysEvents,
  output logic [7:0] cpu_condition_flags
);
  import cpu_status_flags_pkg::*;

  logic [7:0] flags_q;
  logic signCompare_q;
  logic compoundZero_q;
  logic expired_q;
  logic powerDown_q;
  logic signedRange_q;
  logic nullResult_q;
  logic nibbleCarry_q;
  logic outflow_q;
  logic [31:0] readData_q;
  logic ack_q;
  logic aluHold_q;
  logic busReq;
  logic writeHit;
  logic aluFire;
  logic signedRange;

  // one wait cycle per access, answer on the second edge
  assign busReq = (avs_read | avs_write) & ~ack_q;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign writeHit = avs_write & ack_q & (avs_address == FlagsAddr) & avs_byteenable[0];
  // software can freeze the alu update for diagnostics
  assign aluFire = aluFlags.valid & ~aluHold_q;
  // [RQ4] overflow from carries
  assign signedRange = aluFlags.carryIntoMsb ^ aluFlags.carryOut;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      ack_q <= 1'b0;
    else
      ack_q <= busReq;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      readData_q <= ZeroWord;
    else if (busReq & avs_read)
    begin
      case (avs_address)
        FlagsAddr: readData_q <= {24'h00_0000, flags_q};
        AluCtrlAddr: readData_q <= {31'h0000_0000, aluHold_q};
        default: readData_q <= UnmappedRead;
      endcase
    end
  end
  assign avs_readdata = readData_q;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      aluHold_q <= 1'b0;
    else if (avs_write & ack_q & (avs_address == AluCtrlAddr) & avs_byteenable[0])
      aluHold_q <= avs_writedata[0];
  end

  // [RQ9] [RQ1] timeout set wins over clear or halt
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      expired_q <= FlagsReset[WatchdogExpiredBit];
    else if (sysEvents.watchdogTimeout)
      expired_q <= 1'b1;
    else if (sysEvents.watchdogClear | sysEvents.halt)
      expired_q <= 1'b0;
  end

  // [RQ3] [RQ2] halt set wins over clear
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      powerDown_q <= FlagsReset[PowerDownBit];
    else if (sysEvents.halt)
      powerDown_q <= 1'b1;
    else if (sysEvents.watchdogClear)
      powerDown_q <= 1'b0;
  end

  // [RQ7] sign compare, read-only
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      signCompare_q <= FlagsReset[SignCompareBit];
    else if (aluFire & ~aluFlags.isRotate)
      signCompare_q <= signedRange ^ aluFlags.result[DataWidth-1];
  end

  // compound zero loads when the alu qualifies it
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      compoundZero_q <= FlagsReset[CompoundZeroBit];
    else if (aluFire & ~aluFlags.isRotate & aluFlags.czValid)
      compoundZero_q <= aluFlags.czValue;
  end

  // [RQ4] [RQ10] signed range, alu wins over write
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      signedRange_q <= FlagsReset[SignedRangeBit];
    else if (aluFire & ~aluFlags.isRotate)
      signedRange_q <= signedRange;
    else if (writeHit)
      signedRange_q <= avs_writedata[SignedRangeBit];
  end

  // [RQ5] [RQ10] null result
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      nullResult_q <= FlagsReset[NullResultBit];
    else if (aluFire & ~aluFlags.isRotate)
      nullResult_q <= (aluFlags.result == 8'h00);
    else if (writeHit)
      nullResult_q <= avs_writedata[NullResultBit];
  end

  // [RQ6] [RQ10] nibble carry, borrow inverted by alu
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      nibbleCarry_q <= FlagsReset[NibbleCarryBit];
    else if (aluFire & ~aluFlags.isRotate)
      nibbleCarry_q <= aluFlags.nibbleCarry;
    else if (writeHit)
      nibbleCarry_q <= avs_writedata[NibbleCarryBit];
  end

  // [RQ8] [RQ10] outflow, rotate included
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      outflow_q <= FlagsReset[OutflowBit];
    else if (aluFire)
      outflow_q <= aluFlags.carryOut;
    else if (writeHit)
      outflow_q <= avs_writedata[OutflowBit];
  end

  // [RQ11] register view, upper nibble has no write path
  assign flags_q = {signCompare_q, compoundZero_q, expired_q, powerDown_q,
                    signedRange_q, nullResult_q, nibbleCarry_q, outflow_q};
  assign cpu_condition_flags = flags_q;

  chk_expired_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    sysEvents.watchdogTimeout |=> flags_q[WatchdogExpiredBit]) // [RQ9]
    else $error("timeout did not set expired flag");
  chk_expired_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!sysEvents.watchdogTimeout && (sysEvents.watchdogClear || sysEvents.halt))
      |=> !flags_q[WatchdogExpiredBit]) // [RQ1]
    else $error("expired flag not cleared");
  chk_pdown_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (sysEvents.watchdogClear && !sysEvents.halt) |=> !flags_q[PowerDownBit]) // [RQ2]
    else $error("power-down flag not cleared");
  chk_pdown_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    sysEvents.halt |=> flags_q[PowerDownBit]) // [RQ3]
    else $error("halt did not set power-down");
  chk_range_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (aluFire && !aluFlags.isRotate) |=>
      flags_q[SignedRangeBit] == $past(aluFlags.carryIntoMsb ^ aluFlags.carryOut)) // [RQ4]
    else $error("signed range flag wrong");
  chk_null_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (aluFire && !aluFlags.isRotate) |=>
      flags_q[NullResultBit] == ($past(aluFlags.result) == 8'h00)) // [RQ5]
    else $error("null result flag wrong");
  chk_nibble_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (aluFire && !aluFlags.isRotate) |=>
      flags_q[NibbleCarryBit] == $past(aluFlags.nibbleCarry)) // [RQ6]
    else $error("nibble carry flag wrong");
  chk_sign_compare: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (aluFire && !aluFlags.isRotate) |=>
      flags_q[SignCompareBit] == (flags_q[SignedRangeBit] ^ $past(aluFlags.result[7]))) // [RQ7]
    else $error("sign compare flag wrong");
  chk_outflow_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
    aluFire |=> flags_q[OutflowBit] == $past(aluFlags.carryOut)) // [RQ8]
    else $error("outflow flag wrong");
  chk_write_keeps: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (writeHit && !sysEvents.watchdogTimeout && !sysEvents.watchdogClear && !sysEvents.halt)
      |=> $stable(flags_q[7:4]) || ($past(aluFire))) // [RQ10]
    else $error("write changed read-only flags");
  chk_write_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (writeHit && !aluFire) |=> flags_q[3:0] == $past(avs_writedata[3:0])) // [RQ11]
    else $error("writable flags not written");

  chk_wait_first: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ((avs_read || avs_write) && !ack_q) |-> avs_waitrequest)
    else $error("first request cycle not stalled");

  chk_wait_second: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ((avs_read || avs_write) && ack_q) |-> !avs_waitrequest)
    else $error("second request cycle still stalled");

  chk_wait_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high without request");

  chk_ack_single: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ack_q |=> !ack_q)
    else $error("acknowledge held two cycles");

  chk_read_flags: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (busReq && avs_read && avs_address == FlagsAddr) |=> // [RQ11]
      avs_readdata == {24'h00_0000, $past(flags_q)})
    else $error("flag read data wrong");

  chk_read_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (busReq && avs_read && avs_address == AluCtrlAddr) |=>
      avs_readdata == {31'h0000_0000, $past(aluHold_q)})
    else $error("hold read data wrong");

  chk_read_unmapped: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (busReq && avs_read && avs_address != FlagsAddr && avs_address != AluCtrlAddr)
      |=> avs_readdata == UnmappedRead)
    else $error("unmapped read not zero");

  chk_readdata_stable: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !(busReq && avs_read) |=> $stable(avs_readdata))
    else $error("read data changed without read");

  chk_hold_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (avs_write && ack_q && avs_address == AluCtrlAddr && avs_byteenable[0])
      |=> aluHold_q == $past(avs_writedata[0]))
    else $error("hold bit not written");

  chk_hold_freeze: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (aluFlags.valid && aluHold_q && !writeHit)
      |=> $stable({flags_q[7:6], flags_q[3:0]}))
    else $error("alu update not frozen");

  chk_rotate_keeps: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (aluFire && aluFlags.isRotate) |=> // [RQ8]
      $stable({flags_q[7:6], flags_q[3:1]}))
    else $error("rotate changed other flags");

  chk_cz_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (aluFire && !aluFlags.isRotate && aluFlags.czValid)
      |=> flags_q[CompoundZeroBit] == $past(aluFlags.czValue))
    else $error("compound zero not loaded");

  chk_cz_keep: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !(aluFire && !aluFlags.isRotate && aluFlags.czValid)
      |=> $stable(flags_q[CompoundZeroBit]))
    else $error("compound zero changed");

  chk_alu_wins: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (writeHit && aluFire && !aluFlags.isRotate) |=> // [RQ4]
      flags_q[SignedRangeBit] == $past(signedRange))
    else $error("write beat alu update");

  chk_arith_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!aluFire && !writeHit) |=> $stable({flags_q[7:6], flags_q[3:0]}))
    else $error("arith flags changed while idle");

  chk_sys_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !(sysEvents.watchdogTimeout || sysEvents.watchdogClear || sysEvents.halt) // [RQ10]
      |=> $stable(flags_q[5:4]))
    else $error("system flags changed without event");

  chk_pdown_timeout: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!sysEvents.halt && !sysEvents.watchdogClear) |=> // [RQ2]
      $stable(flags_q[PowerDownBit]))
    else $error("power-down changed without halt or clear");

endmodule : cpu_status_flags

// ### rtl/cpu_status_flags_pkg.sv
// package: register map, bit positions and carrier types for the condition flag register
package cpu_status_flags_pkg;
  localparam int unsigned DataWidth = 8;
  localparam int unsigned AddrWidth = 4;
  // word-aligned byte addresses on the register bus
  localparam logic [AddrWidth-1:0] FlagsAddr = 4'h0;
  localparam logic [AddrWidth-1:0] AluCtrlAddr = 4'h4;
  // flag register bit positions
  localparam int unsigned SignCompareBit = 7;
  localparam int unsigned CompoundZeroBit = 6;
  localparam int unsigned WatchdogExpiredBit = 5;
  localparam int unsigned PowerDownBit = 4;
  localparam int unsigned SignedRangeBit = 3;
  localparam int unsigned NullResultBit = 2;
  localparam int unsigned NibbleCarryBit = 1;
  localparam int unsigned OutflowBit = 0;
  localparam logic [7:0] WritableMask = 8'h0F;
  localparam logic [7:0] FlagsReset = 8'h00;
  localparam logic [31:0] UnmappedRead = 32'h0000_0000;
  localparam logic [31:0] ZeroWord = 32'h0000_0000;

  // arithmetic result reported by the core ALU in one cycle
  typedef struct packed {
    logic valid;
    logic isSubtract;
    logic isRotate;
    logic [7:0] result;
    logic carryOut;
    logic carryIntoMsb;
    logic nibbleCarry;
    logic czValid;
    logic czValue;
  } alu_flags_s;

  // system events from watchdog and sleep logic
  typedef struct packed {
    logic watchdogTimeout;
    logic watchdogClear;
    logic halt;
  } sys_events_s;
endpackage : cpu_status_flags_pkg

// ### test/cpu_status_flags_tb_top.sv
// testbench: random alu, event and bus traffic against the flag register
`timescale 1ns/10ps
module cpu_status_flags_tb_top;
  import cpu_status_flags_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [AddrWidth-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  alu_flags_s aluFlags = '0;
  sys_events_s sysEvents = '0;
  logic [7:0] cpu_condition_flags;
  logic [7:0] model = 8'h00;
  logic [31:0] rd;
  integer seed = 32'h1b47_fbba;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  always #10 clk_sys = ~clk_sys;
  cpu_status_flags u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .aluFlags(aluFlags), .sysEvents(sysEvents),
    .cpu_condition_flags(cpu_condition_flags));
  // expected flags after one alu result
  function automatic logic [7:0] aluExp(input logic [7:0] f, input alu_flags_s a);
    logic [7:0] n;
    n = f;
    n[0] = a.carryOut;
    if (!a.isRotate)
    begin
      n[3] = a.carryIntoMsb ^ a.carryOut;
      n[2] = (a.result == 8'h00);
      n[1] = a.nibbleCarry;
      n[7] = n[3] ^ a.result[7];
      if (a.czValid) n[6] = a.czValue;
    end
    return n;
  endfunction : aluExp
  // expected flags after system events
  function automatic logic [7:0] evExp(input logic [7:0] f, input sys_events_s e);
    logic [7:0] n;
    n = f;
    if (e.watchdogClear) n[5:4] = 2'b00;
    if (e.halt) n[5:4] = 2'b01;
    if (e.watchdogTimeout) n[5] = 1'b1;
    return n;
  endfunction : evExp
  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : check
  task automatic summarize;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  // one bus access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     input logic [3:0] be);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    avs_byteenable <= be;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(negedge clk_sys);
  endtask : bus
  task automatic pulse(input alu_flags_s a, input sys_events_s e);
    @(posedge clk_sys);
    aluFlags <= a;
    sysEvents <= e;
    @(posedge clk_sys);
    aluFlags <= '0;
    sysEvents <= '0;
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : pulse
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fails++;
      summarize();
    end
  end
  initial
  begin
    alu_flags_s a;
    sys_events_s e;
    logic [31:0] r;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    bus(1'b0, FlagsAddr, ZeroWord, 4'hf);
    check({24'h0, FlagsReset}, rd);
    $display("test reset done");
    repeat (300)
    begin
      r = $random(seed);
      a = alu_flags_s'(r[31:16]);
      a.valid = 1'b1;
      if (r[3:2] == 2'b00) a.result = 8'h00;
      e = sys_events_s'(r[6:4]);
      case (r[1:0])
        2'd0:
        begin
          pulse(a, '0);
          model = aluExp(model, a);
          check(model, cpu_condition_flags);
        end
        2'd1:
        begin
          pulse('0, e);
          model = evExp(model, e);
          check(model, cpu_condition_flags);
        end
        2'd2:
        begin
          bus(1'b1, FlagsAddr, r, {3'b111, r[4]});
          if (r[4]) model[3:0] = r[3:0];
          check(model, cpu_condition_flags);
        end
        default:
        begin
          bus(1'b0, FlagsAddr, ZeroWord, 4'hf);
          check({24'h0, model}, rd);
        end
      endcase
    end
    $display("test random mix done");
    bus(1'b1, 4'hc, 32'hffff_ffff, 4'hf);
    check(model, cpu_condition_flags);
    bus(1'b0, 4'h8, ZeroWord, 4'hf);
    check(UnmappedRead, rd);
    $display("test unmapped done");
    bus(1'b1, AluCtrlAddr, 32'h0000_0001, 4'hf);
    bus(1'b0, AluCtrlAddr, ZeroWord, 4'hf);
    check(32'h0000_0001, rd);
    a = '0;
    a.valid = 1'b1;
    a.carryOut = ~model[0];
    a.result = 8'h80;
    pulse(a, '0);
    check(model, cpu_condition_flags);
    bus(1'b1, AluCtrlAddr, ZeroWord, 4'hf);
    pulse(a, '0);
    model = aluExp(model, a);
    check(model, cpu_condition_flags);
    $display("test alu hold done");
    summarize();
  end
endmodule : cpu_status_flags_tb_top
